// *** add_logic_branch_exec_tb.sv ***
// Self-checking bench for the add, logic and branch execute unit
`timescale 1ns/1ps
module add_logic_branch_exec_tb;
  import alb_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  alb_state_t state;
  int miscompares = 0;
  int checked = 0;
  alb_exec #(.ADDR_W(8)) u_alb_exec (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .state(state));
  alb_apb_bfm u_alb_apb_bfm (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic stop_test;
    if (miscompares == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    u_alb_apb_bfm.xfer(1'b1, a, d, r, e);
    chk({31'h0, e}, 32'h0);
  endtask
  task automatic expect_reg(input logic [7:0] a, input logic [31:0] m,
                            input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    u_alb_apb_bfm.xfer(1'b0, a, 32'h0, r, e);
    chk({31'h0, e}, 32'h0);
    chk(r & m, exp);
  endtask
  task automatic load(input logic [31:0] current_insn_addr, sa, sb, cr, fixed_point_exception_reg, ctr, lr);
    wr(OFF_CIA, current_insn_addr);
    wr(OFF_SRC_A, sa);
    wr(OFF_SRC_B, sb);
    wr(OFF_CR, cr);
    wr(OFF_XER, fixed_point_exception_reg);
    wr(OFF_CTR, ctr);
    wr(OFF_LR, lr);
  endtask
  task automatic t_reset_map;
    logic [31:0] r;
    logic e;
    expect_reg(OFF_CTR, '1, RST_WORD);
    expect_reg(OFF_STATUS, '1, RST_WORD);
    u_alb_apb_bfm.xfer(1'b1, OFF_RESULT, 32'h1, r, e);
    chk({31'h0, e}, 32'h1);
    u_alb_apb_bfm.xfer(1'b0, 8'h2c, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    expect_reg(OFF_RESULT, '1, RST_WORD);
  endtask
  task automatic addze_one(input logic [31:0] a, fixed_point_exception_reg, input logic oe, rc,
                           input logic [31:0] res, xer_e, cr_e);
    load(32'h100, a, 32'h0, 32'h0, fixed_point_exception_reg, 32'h0, 32'h0);
    wr(OFF_INSN, {6'd31, 5'd3, 5'd4, 5'd0, oe, 9'd202, rc});
    @(negedge pclk);
    chk({30'h0, state}, {30'h0, ALB_EXEC});
    expect_reg(OFF_RESULT, '1, res);
    expect_reg(OFF_XER, '1, xer_e);
    expect_reg(OFF_CR, '1, cr_e);
    expect_reg(OFF_STATUS, 32'h3ef, 32'h63);
    expect_reg(OFF_NIA, '1, 32'h104);
  endtask
  task automatic t_addze;
    addze_one(32'h7fffffff, 32'h20000000, 1'b1, 1'b1, 32'h80000000,
              32'hc0000000, 32'h90000000);
    addze_one(32'h7fffffff, 32'h20000000, 1'b0, 1'b0, 32'h80000000,
              32'h00000000, 32'h0);
    addze_one(32'hffffffff, 32'h20000000, 1'b0, 1'b1, 32'h0,
              32'h20000000, 32'h20000000);
  endtask
  task automatic logic_one(input logic [31:0] insn, res, cr_e);
    load(32'h200, 32'hf0f09234, 32'h0ff000ff, 32'h0, 32'h80000000,
         32'h0, 32'h0);
    wr(OFF_INSN, insn);
    expect_reg(OFF_RESULT, '1, res);
    expect_reg(OFF_CR, '1, cr_e);
    expect_reg(OFF_STATUS, 32'h3ef, 32'hc3);
  endtask
  task automatic t_logic;
    logic_one({6'd31, 5'd5, 5'd6, 5'd7, 10'd28, 1'b1}, 32'h00f00034,
              32'h50000000);
    logic_one({6'd31, 5'd5, 5'd6, 5'd7, 10'd60, 1'b0}, 32'hf0009200,
              32'h0);
    logic_one({6'd28, 5'd5, 5'd6, 16'h8001}, 32'h00008000,
              32'h50000000);
    logic_one({6'd29, 5'd5, 5'd6, 16'h8001}, 32'h80000000,
              32'h90000000);
  endtask
  task automatic t_branch;
    load(32'h1000, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h5555);
    wr(OFF_INSN, {6'd18, 24'hfffffc, 1'b0, 1'b1});
    expect_reg(OFF_NIA, '1, 32'h0ff0);
    expect_reg(OFF_LR, '1, 32'h1004);
    expect_reg(OFF_STATUS, 32'h4, 32'h4);
    wr(OFF_LR, 32'h5555);
    wr(OFF_INSN, {6'd18, 24'h000010, 1'b1, 1'b0});
    expect_reg(OFF_NIA, '1, 32'h40);
    expect_reg(OFF_LR, '1, 32'h5555);
  endtask
  task automatic bc_one(input logic [4:0] bo, bi, input logic aa,
                        input logic [13:0] bd, input logic [31:0] ctr,
                        input logic tk, input logic [31:0] ctr_e);
    logic [31:0] sx;
    sx = {{16{bd[13]}}, bd, 2'b00};
    load(32'h2000, 32'h0, 32'h0, 32'h20000000, 32'h0, ctr, 32'h7777);
    wr(OFF_INSN, {6'd16, bo, bi, bd, aa, 1'b1});
    expect_reg(OFF_NIA, '1,
               tk ? (aa ? sx : 32'h2000 + sx) : 32'h2004);
    expect_reg(OFF_CTR, '1, ctr_e);
    expect_reg(OFF_LR, '1, 32'h2004);
    expect_reg(OFF_STATUS, 32'h14, {27'h0, bo[0], 1'b0, tk, 2'b0});
  endtask
  task automatic t_bc;
    bc_one(5'b10000, 5'd0, 1'b0, 14'h4, 32'd2, 1'b1, 32'd1);
    bc_one(5'b10010, 5'd0, 1'b0, 14'h4, 32'd2, 1'b0, 32'd1);
    bc_one(5'b00010, 5'd0, 1'b0, 14'h4, 32'd1, 1'b1, 32'd0);
    bc_one(5'b00000, 5'd0, 1'b0, 14'h4, 32'd1, 1'b0, 32'd0);
    bc_one(5'b01000, 5'd2, 1'b0, 14'h4, 32'd1, 1'b0, 32'd0);
    bc_one(5'b01100, 5'd2, 1'b0, 14'h4, 32'd5, 1'b1, 32'd5);
    bc_one(5'b01110, 5'd2, 1'b0, 14'h4, 32'd5, 1'b1, 32'd5);
    bc_one(5'b01101, 5'd2, 1'b0, 14'h4, 32'd5, 1'b1, 32'd5);
    bc_one(5'b00100, 5'd2, 1'b0, 14'h4, 32'd5, 1'b0, 32'd5);
    bc_one(5'b00101, 5'd0, 1'b0, 14'h4, 32'd5, 1'b1, 32'd5);
    bc_one(5'b10100, 5'd0, 1'b1, 14'h3ffc, 32'd5, 1'b1, 32'd5);
    bc_one(5'b11111, 5'd0, 1'b0, 14'h3ffe, 32'd5, 1'b1, 32'd5);
  endtask
  task automatic t_bcctr;
    load(32'h3000, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1237, 32'h0);
    wr(OFF_INSN, {6'd19, 5'b10100, 5'd0, 5'd0, 10'd528, 1'b1});
    expect_reg(OFF_NIA, '1, 32'h1234);
    expect_reg(OFF_LR, '1, 32'h3004);
    wr(OFF_INSN, {6'd19, 5'b01100, 5'd0, 5'd0, 10'd528, 1'b0});
    expect_reg(OFF_NIA, '1, 32'h3004);
    wr(OFF_INSN, {6'd19, 5'b00000, 5'd0, 5'd0, 10'd528, 1'b1});
    expect_reg(OFF_STATUS, 32'hf, 32'h9);
    expect_reg(OFF_NIA, '1, 32'h3004);
    expect_reg(OFF_CTR, '1, 32'h1237);
  endtask
  initial begin
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_map;
    t_addze;
    t_logic;
    t_branch;
    t_bc;
    t_bcctr;
    stop_test;
  end
  // Whole run is about 800 cycles; this is far beyond it
  initial begin
    #500000;
    miscompares++;
    stop_test;
  end
endmodule

// *** alb_apb_bfm.sv ***
// APB master model standing in for the instruction source and GPR file
`timescale 1ns/1ps
module alb_apb_bfm (
  // Clock
  input wire logic pclk,
  // APB request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // APB answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // Request holds until pready is seen high at a rising edge; answer is
  // taken at that edge; only the bench watchdog limits the wait
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released bus shows junk so a stale value cannot look valid
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// *** alb_cr_field.sv ***
// Less-than, greater-than, equal and summary-overflow from a result
`timescale 1ns/1ps
module alb_cr_field (
  // Result and sticky overflow
  input wire logic [31:0] value,
  input wire logic so,
  // Field, lt first
  output logic [3:0] field
);
  always_comb begin
    field[3] = value[31];
    field[2] = !value[31] && (value != 32'h0000_0000);
    field[1] = (value == 32'h0000_0000);
    field[0] = so;
  end
endmodule

// *** alb_exec.sv ***
// APB slave that decodes and executes add, logic and branch instructions
// Notes on behaviour
// [RULE1] Add-to-zero-extended adds first source and carry
// [RULE2] Record bit updates first condition field
// [RULE3] Carry always; overflow, summary only with enable
// [RULE4] Register AND writes source and second source
// [RULE5] AND with complement of second source
// [RULE6] Low-half immediate AND, always records
// [RULE7] High-half immediate AND, always records
// [RULE8] Relative branch adds displacement to address
// [RULE9] Absolute branch uses displacement alone
// [RULE10] Save-return loads link with address plus 4
// [RULE11] Conditional target relative or absolute
// [RULE12] Selected condition bit compared with expected
// [RULE13] Option bit 2 clear decrements, bit 3 tests
// [RULE14] Condition-only and always patterns keep counter
// [RULE15] Don't-care option bits never affect outcome
// [RULE16] Hint bit never changes outcome
// [RULE17] Branch to counter with low bits cleared
// [RULE18] Counter branch with decrement is invalid
// [RULE19] Conditional branch opcode and field positions
// [RULE20] Carry is unsigned carry out of sum
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
module alb_exec #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Execution state
  output alb_pkg::alb_state_t state
);
  import alb_pkg::*;
  default clocking cb_chk @(posedge pclk); endclocking
  default disable iff (!presetn);

  if (ADDR_W < 6) begin : g_bad_addr
    $error("ADDR_W must cover the register map");
  end

  logic [31:0] insn, current_insn_addr, src_a, src_b, cr, fixed_point_exception_reg, ctr, lr;
  logic [31:0] result, nia, status;
  logic [7:0] addr;
  logic apb_done, wr_en, rd_ok, exec_go;
  logic [31:0] rd_mux;

  assign addr = 8'(paddr);
  assign apb_done = psel && penable && pready;
  // A refused write must leave every register alone, aliases included
  assign wr_en = apb_done && pwrite && !pslverr;
  assign exec_go = (state == ALB_EXEC);

  // Decode
  logic [5:0] opcd;
  logic [4:0] bo_f, bi_f, dest;
  logic is_addze, is_and, is_andc, is_andi, is_andis;
  logic is_b, is_bc, is_bcctr, is_branch, invalid, lk, aa;
  logic rec_en, oe, gpr_wr;
  assign opcd = insn[31:26];
  assign bo_f = insn[25:21]; // [RULE19]
  assign bi_f = insn[20:16]; // [RULE19]
  assign dest = (is_addze) ? insn[25:21] : insn[20:16];
  assign lk = insn[POS_LINK];
  assign aa = insn[POS_ABS];
  assign oe = insn[POS_OE];
  assign is_addze = (opcd == OP_EXT31) && (insn[9:1] == XO_ADDZE); // [RULE1]
  assign is_and = (opcd == OP_EXT31) && (insn[10:1] == XO_AND); // [RULE4]
  assign is_andc = (opcd == OP_EXT31) && (insn[10:1] == XO_ANDC); // [RULE5]
  assign is_andi = (opcd == OP_ANDI); // [RULE6]
  assign is_andis = (opcd == OP_ANDIS); // [RULE7]
  assign is_b = (opcd == OP_B); // [RULE8]
  assign is_bc = (opcd == OP_BC); // [RULE19]
  assign is_bcctr = (opcd == OP_EXT19) && (insn[10:1] == XO_BCCTR); // [RULE17]
  assign is_branch = is_b || is_bc || is_bcctr;
  // Counter branches cannot decrement the register they jump through
  assign invalid = (is_bcctr && !bo_f[2]) || // [RULE18]
    !(is_addze || is_and || is_andc || is_andi || is_andis || is_branch);
  assign rec_en = ((is_addze || is_and || is_andc) && insn[POS_RECORD])
    || is_andi || is_andis; // [RULE2]
  assign gpr_wr = is_addze || is_and || is_andc || is_andi || is_andis;

  // Arithmetic and logic
  logic [32:0] add_sum;
  logic xer_ca, add_ov, next_so;
  logic [31:0] next_result;
  assign xer_ca = fixed_point_exception_reg[XER_CA];
  assign add_sum = {1'b0, src_a} + {32'h0000_0000, xer_ca}; // [RULE20]
  assign add_ov = !src_a[31] && add_sum[31];
  assign next_so = fixed_point_exception_reg[XER_SO] || (is_addze && oe && add_ov); // [RULE3]

  always_comb begin
    next_result = result;
    if (is_addze) begin
      next_result = add_sum[31:0]; // [RULE1]
    end else if (is_and) begin
      next_result = src_a & src_b; // [RULE4]
    end else if (is_andc) begin
      next_result = src_a & ~src_b; // [RULE5]
    end else if (is_andi) begin
      next_result = src_a & {16'h0000, insn[15:0]}; // [RULE6]
    end else if (is_andis) begin
      next_result = src_a & {insn[15:0], 16'h0000}; // [RULE7]
    end
  end

  logic [3:0] cr0_new;
  alb_cr_field u_cr0 (
    .value(next_result),
    .so(next_so),
    .field(cr0_new)
  );

  // Branch outcome
  logic [31:0] li_ext, bd_ext, ctr_dec, b_target, bc_target;
  logic cond_bit, cond_ok, ctr_ok, taken;
  logic [31:0] next_nia;
  assign li_ext = {{6{insn[25]}}, insn[25:2], 2'b00};
  assign bd_ext = {{16{insn[15]}}, insn[15:2], 2'b00};
  assign b_target = aa ? li_ext : current_insn_addr + li_ext; // [RULE8] [RULE9]
  assign bc_target = aa ? bd_ext : current_insn_addr + bd_ext; // [RULE11]
  assign ctr_dec = ctr - 32'h0000_0001;
  assign cond_bit = cr[5'd31 - bi_f]; // [RULE12]
  // Bit 3 is only consulted when decrementing, so 001zy keeps its z free
  assign ctr_ok = bo_f[2] || ((ctr_dec != 32'h0000_0000) ^ bo_f[1]);
  assign cond_ok = bo_f[4] || (cond_bit == bo_f[3]); // [RULE12] [RULE14]
  // The hint bit bo_f[0] is reported only; [RULE15] [RULE16]
  always_comb begin
    taken = 1'b0;
    next_nia = current_insn_addr + LINK_STEP;
    if (is_b) begin
      taken = 1'b1;
      next_nia = b_target;
    end else if (is_bc) begin
      taken = ctr_ok && cond_ok; // [RULE13] [RULE14]
      if (taken) begin
        next_nia = bc_target;
      end
    end else if (is_bcctr) begin
      taken = cond_ok;
      if (taken) begin
        next_nia = {ctr[31:2], 2'b00}; // [RULE17]
      end
    end
  end

  // Sequencing: a write to the instruction word starts one execute cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ALB_IDLE;
    end else begin
      case (state)
        ALB_IDLE: begin
          if (wr_en && addr == OFF_INSN) begin
            state <= ALB_EXEC;
          end
        end
        ALB_EXEC: state <= ALB_IDLE;
        default: state <= ALB_IDLE;
      endcase
    end
  end

  // Software-loaded operands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      insn <= RST_INSN;
      current_insn_addr <= RST_WORD;
      src_a <= RST_WORD;
      src_b <= RST_WORD;
    end else if (wr_en) begin
      case (addr)
        OFF_INSN: insn <= pwdata;
        OFF_CIA: current_insn_addr <= pwdata;
        OFF_SRC_A: src_a <= pwdata;
        OFF_SRC_B: src_b <= pwdata;
        default: ;
      endcase
    end
  end

  // Condition register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cr <= RST_WORD;
    end else if (wr_en && addr == OFF_CR) begin
      cr <= pwdata;
    end else if (exec_go && !invalid && rec_en) begin
      cr[CR_LT -: 4] <= cr0_new; // [RULE2] [RULE6] [RULE7]
    end
  end

  // Exception register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fixed_point_exception_reg <= RST_WORD;
    end else if (wr_en && addr == OFF_XER) begin
      fixed_point_exception_reg <= pwdata;
    end else if (exec_go && !invalid && is_addze) begin
      fixed_point_exception_reg[XER_CA] <= add_sum[32]; // [RULE3] [RULE20]
      if (oe) begin
        fixed_point_exception_reg[XER_OV] <= add_ov; // [RULE3]
        fixed_point_exception_reg[XER_SO] <= next_so;
      end
    end
  end

  // Loop counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctr <= RST_WORD;
    end else if (wr_en && addr == OFF_CTR) begin
      ctr <= pwdata;
    end else if (exec_go && !invalid && is_bc && !bo_f[2]) begin
      ctr <= ctr_dec; // [RULE13]
    end
  end

  // Return link
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lr <= RST_WORD;
    end else if (wr_en && addr == OFF_LR) begin
      lr <= pwdata;
    end else if (exec_go && !invalid && is_branch && lk) begin
      lr <= current_insn_addr + LINK_STEP; // [RULE10]
    end
  end

  // Results and status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result <= RST_WORD;
      nia <= RST_WORD;
      status <= RST_WORD;
    end else if (wr_en && addr == OFF_INSN) begin
      status[ST_DONE] <= 1'b0;
    end else if (exec_go) begin
      status <= RST_WORD;
      status[ST_DONE] <= 1'b1;
      status[ST_INVALID] <= invalid; // [RULE18]
      if (!invalid) begin
        result <= next_result;
        nia <= next_nia;
        status[ST_GPR_WR] <= gpr_wr;
        status[ST_TAKEN] <= taken;
        status[ST_HINT] <= (is_bc || is_bcctr) && bo_f[0]; // [RULE16]
        status[ST_DEST +: 5] <= dest;
      end
    end
  end

  // APB read decode
  always_comb begin
    rd_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    case (addr)
      OFF_INSN: rd_mux = insn;
      OFF_CIA: rd_mux = current_insn_addr;
      OFF_SRC_A: rd_mux = src_a;
      OFF_SRC_B: rd_mux = src_b;
      OFF_CR: rd_mux = cr;
      OFF_XER: rd_mux = fixed_point_exception_reg;
      OFF_CTR: rd_mux = ctr;
      OFF_LR: rd_mux = lr;
      OFF_RESULT: rd_mux = result;
      OFF_NIA: rd_mux = nia;
      OFF_STATUS: rd_mux = status;
      default: rd_ok = 1'b0;
    endcase
    if (pwrite && addr >= OFF_RESULT) begin
      rd_ok = 1'b0;
    end
    if (paddr > ADDR_W'(OFF_STATUS)) begin
      rd_ok = 1'b0;
    end
  end

  // Answer is held off during an execute cycle so reads never see stale data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= RST_WORD;
    end else if (psel && !pready && !exec_go) begin
      pready <= 1'b1;
      pslverr <= !rd_ok;
      prdata <= (pwrite || !rd_ok) ? RST_WORD : rd_mux;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Checks
  sequence s_exec(logic kind);
    exec_go && !invalid && kind;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  property p_addze_sum;
    s_exec(is_addze) |=> result == $past(src_a) + {31'h0, $past(xer_ca)};
  endproperty
  a_addze_sum: assert property (p_addze_sum) // [RULE1]
    else $error("addze result wrong");
  property p_record_eq;
    s_exec(rec_en) |=> cr[CR_LT-2] == (result == 32'h0)
      && cr[CR_LT] == result[31];
  endproperty
  a_record_eq: assert property (p_record_eq) // [RULE2]
    else $error("first condition field not recorded");
  property p_ov_only_oe;
    s_exec(is_addze && !oe) |=> $stable(fixed_point_exception_reg[XER_SO:XER_OV])
      && fixed_point_exception_reg[XER_CA] == $past(add_sum[32]);
  endproperty
  a_ov_only_oe: assert property (p_ov_only_oe) // [RULE3]
    else $error("overflow flags touched without enable");
  property p_andc_value;
    s_exec(is_andc) |=> result == ($past(src_a) & ~$past(src_b));
  endproperty
  a_andc_value: assert property (p_andc_value) // [RULE5]
    else $error("and-with-complement result wrong");
  property p_andis_value;
    s_exec(is_andis) |=> result[15:0] == 16'h0000 && status[ST_GPR_WR];
  endproperty
  a_andis_value: assert property (p_andis_value) // [RULE7]
    else $error("shifted immediate and leaked low half");
  property p_branch_rel;
    s_exec(is_b && !aa) |=> nia == $past(current_insn_addr) + $past(li_ext)
      && status[ST_TAKEN];
  endproperty
  a_branch_rel: assert property (p_branch_rel) // [RULE8]
    else $error("relative branch target wrong");
  property p_link;
    s_exec(is_branch && lk) |=> lr == $past(current_insn_addr) + 32'h4;
  endproperty
  a_link: assert property (p_link) // [RULE10]
    else $error("return link not loaded");
  property p_ctr_dec;
    s_exec(is_bc) |=> (ctr == $past(ctr) - 32'h1) == !$past(bo_f[2]);
  endproperty
  a_ctr_dec: assert property (p_ctr_dec) // [RULE13]
    else $error("loop counter decrement wrong");
  property p_ctr_target;
    s_exec(is_bcctr && cond_ok) |=> nia == {$past(ctr[31:2]), 2'b00};
  endproperty
  a_ctr_target: assert property (p_ctr_target) // [RULE17]
    else $error("counter branch target wrong");
  property p_bcctr_inv;
    exec_go && is_bcctr && !bo_f[2] |=> status[ST_INVALID] && $stable(lr)
      && $stable(ctr);
  endproperty
  a_bcctr_inv: assert property (p_bcctr_inv) // [RULE18]
    else $error("invalid counter branch executed");
  property p_apb_answer;
    psel && !penable && !pready && !exec_go |=> s_answer;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("APB answer not one cycle");
endmodule

// *** alb_pkg.sv ***
// Constants for the add, logic and branch execute unit
package alb_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_INSN = 8'h00;
  localparam logic [7:0] OFF_CIA = 8'h04;
  localparam logic [7:0] OFF_SRC_A = 8'h08;
  localparam logic [7:0] OFF_SRC_B = 8'h0c;
  localparam logic [7:0] OFF_CR = 8'h10;
  localparam logic [7:0] OFF_XER = 8'h14;
  localparam logic [7:0] OFF_CTR = 8'h18;
  localparam logic [7:0] OFF_LR = 8'h1c;
  localparam logic [7:0] OFF_RESULT = 8'h20;
  localparam logic [7:0] OFF_NIA = 8'h24;
  localparam logic [7:0] OFF_STATUS = 8'h28;
  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [31:0] RST_INSN = 32'h0000_0000;
  // Opcodes
  localparam logic [5:0] OP_EXT31 = 6'h1f;
  localparam logic [5:0] OP_ANDI = 6'h1c;
  localparam logic [5:0] OP_ANDIS = 6'h1d;
  localparam logic [5:0] OP_B = 6'h12;
  localparam logic [5:0] OP_BC = 6'h10;
  localparam logic [5:0] OP_EXT19 = 6'h13;
  localparam logic [8:0] XO_ADDZE = 9'h0ca;
  localparam logic [9:0] XO_AND = 10'h01c;
  localparam logic [9:0] XO_ANDC = 10'h03c;
  localparam logic [9:0] XO_BCCTR = 10'h210;
  // Instruction field positions (bit 0 of the word is its lsb)
  localparam int POS_RECORD = 0;
  localparam int POS_LINK = 0;
  localparam int POS_ABS = 1;
  localparam int POS_OE = 10;
  // Flag positions in the condition and exception registers
  localparam int CR_LT = 31;
  localparam int XER_SO = 31;
  localparam int XER_OV = 30;
  localparam int XER_CA = 29;
  // Status word layout
  localparam int ST_DONE = 0;
  localparam int ST_GPR_WR = 1;
  localparam int ST_TAKEN = 2;
  localparam int ST_INVALID = 3;
  localparam int ST_HINT = 4;
  localparam int ST_DEST = 5;
  localparam logic [31:0] LINK_STEP = 32'h0000_0004;
  typedef enum logic [1:0] {
    ALB_IDLE = 2'b00,
    ALB_EXEC = 2'b01
  } alb_state_t;
endpackage
